/* design/fcfg_flash_ctrl.sv */
// Flash command decoder, lock table, read config and read path
//
// The implementer's own choices: the APB register port and the placing of the registers.
module fcfg_flash_ctrl
  import fcfg_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // Flash bus pins
  input  wire logic                chip_sel_n_i,
  input  wire logic                address_valid_n_i,
  input  wire logic                write_en_n_i,
  input  wire logic                output_en_n_i,
  input  wire logic                flash_clk_i,
  input  wire logic [ADDR_W-1:0]   flash_addr_i,
  input  wire logic [DATA_W-1:0]   dq_i,
  output logic      [DATA_W-1:0]   dq_o,
  output logic                     dq_oe_o,
  output logic                     wait_o
);
  logic [SYNC_W-1:0]  pins_s;
  logic [3:0]         prev_q;
  fcfg_dec_e          dec_q, dec_d;
  fcfg_rstate_e       rstate_q, rstate_d;
  fcfg_burst_e        br_q, br_d;
  logic [15:0]        rcr_q, rcr_d;
  logic [1:0]         err_q;
  logic [1:0]         lock_q [NUM_BLK];
  logic [7:0]         prog_cnt_q;
  logic [ADDR_W-1:0]  prot_addr_q;
  logic [DATA_W-1:0]  prot_data_q;
  logic [ADDR_W-1:0]  cur_q, cur_d;
  logic [2:0]         acc_q;
  logic [2:0]         lat_q, lat_d;
  logic [4:0]         left_q, left_d;
  logic               word_ld;
  logic [ARR_AW-1:0]  arr_addr_q;
  logic               lock_cmd, cfg_load, prot_start, err_set, err_clr_cmd;
  logic [DATA_W-1:0]  sel_word;
  logic [31:0]        rd_mux;
  logic [2*NUM_BLK-1:0] lock_flat;
  fcfg_mem_if mem_bus ();
  fcfg_in_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .in_i  ({chip_sel_n_i, address_valid_n_i, write_en_n_i, output_en_n_i,
             flash_clk_i, flash_addr_i, dq_i}),
    .out_o (pins_s)
  );
  fcfg_page_mem u_mem (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (mem_bus.mem)
  );
  // Synchronised pins and their edges
  wire logic              ce_n   = pins_s[36];
  wire logic              adv_n  = pins_s[35];
  wire logic              we_n   = pins_s[34];
  wire logic              oe_n   = pins_s[33];
  wire logic              fclk   = pins_s[32];
  wire logic [ADDR_W-1:0] addr   = pins_s[31:16];
  wire logic [DATA_W-1:0] din    = pins_s[15:0];
  wire logic [7:0]        code   = din[7:0];
  wire logic [BLK_W-1:0]  blk    = addr[ADDR_W-1:BLK_LO];
  wire logic              wr_evt   = we_n & ~prev_q[1] & ~prev_q[3];
  wire logic              fclk_rise = fclk & ~prev_q[0];
  wire logic              adv_rise  = adv_n & ~prev_q[2] & ~ce_n;
  wire logic              ce_fall   = ~ce_n & prev_q[3];
  wire logic              rd_async  = rcr_q[RCR_MODE_BIT];
  wire logic [2:0]        lc        = rcr_q[RCR_LC_HI:RCR_LC_LO];
  wire logic [2:0]        bl        = rcr_q[RCR_BL_HI:RCR_BL_LO];
  wire logic              bl_cont   = !(bl == BL_4 || bl == BL_8 ||
                                        bl == BL_16);
  wire logic [4:0]        burst_words = (bl == BL_4) ? 5'h04 :
                                        (bl == BL_8) ? 5'h08 : 5'h10;
  wire logic              prog_idle = (prog_cnt_q == 8'h00);
  wire logic [15:0]       sr_word   = {8'h00, prog_idle, 1'b0, err_q, 4'h0};
  wire logic [1:0]        lock_cur  = lock_q[blk];
  wire logic [DATA_W-1:0] page_word =
    mem_bus.rpage[{cur_q[1:0], 4'h0} +: DATA_W];
  // APB decode
  wire logic apb_setup = psel_i & ~penable_i;
  wire logic apb_wr    = psel_i & penable_i & pwrite_i & pready_o;
  wire logic hit_stat  = (paddr_i == OFF_STATUS);
  wire logic hit_cfg   = (paddr_i == OFF_RDCFG);
  wire logic hit_rst   = (paddr_i == OFF_RDSTATE);
  wire logic hit_lock  = (paddr_i == OFF_LOCKS);
  wire logic hit_aadr  = (paddr_i == OFF_ARR_ADDR);
  wire logic hit_adat  = (paddr_i == OFF_ARR_DATA);
  wire logic hit_prot  = (paddr_i == OFF_PROT);
  wire logic mapped    = hit_stat | hit_cfg | hit_rst | hit_lock |
                         hit_aadr | hit_adat | hit_prot;
  wire logic [1:0] sw_clr = (apb_wr & hit_stat) ? pwdata_i[5:4] : 2'h0;
  always_comb begin
    if (hit_stat)      rd_mux = {16'h0000, sr_word};
    else if (hit_cfg)  rd_mux = {16'h0000, rcr_q};
    else if (hit_rst)  rd_mux = {28'h000_0000, dec_q, rstate_q};
    else if (hit_lock) rd_mux = lock_flat;
    else if (hit_aadr) rd_mux = {26'h000_0000, arr_addr_q};
    else if (hit_prot) rd_mux = {prot_data_q, prot_addr_q};
    else               rd_mux = 32'h0000_0000;
  end
  assign mem_bus.we    = apb_wr & hit_adat;
  assign mem_bus.waddr = arr_addr_q;
  assign mem_bus.wdata = pwdata_i[DATA_W-1:0];
  assign mem_bus.raddr = cur_q[ARR_AW-1:2];
  // Command decoder
  always_comb begin
    dec_d       = dec_q;
    rstate_d    = rstate_q;
    rcr_d       = (apb_wr & hit_cfg) ? pwdata_i[15:0] : rcr_q;
    lock_cmd    = 1'b0;
    cfg_load    = 1'b0;
    prot_start  = 1'b0;
    err_set     = 1'b0;
    err_clr_cmd = 1'b0;
    if (wr_evt) begin
      case (dec_q)
        DEC_SETUP: begin
          dec_d = DEC_IDLE;
          if (code == CMD_LOCK || code == CMD_UNLOCK ||
              code == CMD_LOCKDOWN) begin
            lock_cmd = 1'b1;
          end else if (code == CMD_LOAD_CFG) begin
            cfg_load = 1'b1;
            rcr_d    = addr;
            rstate_d = RS_ARRAY;
          end else begin
            err_set = 1'b1;
          end
        end
        DEC_PROT: begin
          dec_d      = DEC_IDLE;
          prot_start = 1'b1;
        end
        default: begin
          if (code == CMD_SETUP_SHARED) dec_d = DEC_SETUP;
          else if (code == CMD_PROT_SETUP) dec_d = DEC_PROT;
          else if (code == CMD_CLEAR_STATUS) err_clr_cmd = 1'b1;
          else if (code == CMD_READ_ARRAY) rstate_d = RS_ARRAY;
          else if (code == CMD_READ_IDENT) rstate_d = RS_IDENT;
          else if (code == CMD_READ_STATUS) rstate_d = RS_STATUS;
          else if (code == CMD_READ_QUERY) rstate_d = RS_QUERY;
        end
      endcase
    end
  end
  wire logic [1:0] lock_nxt =
    (code == CMD_LOCK)                   ? {lock_cur[1], 1'b1} :
    (code == CMD_UNLOCK && !lock_cur[1]) ? 2'h0 :
    (code == CMD_LOCKDOWN)               ? 2'h3 : lock_cur;
  // Lock table, one entry per block
  for (genvar b = 0; b < NUM_BLK; b++) begin : g_blk
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) lock_q[b] <= LOCK_RST;
      else if (lock_cmd && blk == BLK_W'(b)) lock_q[b] <= lock_nxt;
    end
    assign lock_flat[2*b +: 2] = lock_q[b];
  end
  // Read word by read state
  always_comb begin
    case (rstate_q)
      RS_ARRAY:  sel_word = page_word;
      RS_IDENT:  sel_word = (cur_q[7:0] == ID_OFF_CFG) ? rcr_q : ID_WORD;
      RS_STATUS: sel_word = sr_word;
      default:   sel_word = QUERY_WORD;
    endcase
  end
  // Address latch and burst sequencing
  always_comb begin
    cur_d   = cur_q;
    br_d    = br_q;
    lat_d   = lat_q;
    left_d  = left_q;
    word_ld = 1'b0;
    if (ce_n) begin
      br_d = BR_IDLE;
    end else if (rd_async) begin
      br_d = BR_IDLE;
      if (!adv_n) cur_d = addr;
    end else if (adv_rise || (br_q == BR_IDLE && fclk_rise && !adv_n)) begin
      cur_d = addr;
      lat_d = lc;
      br_d  = BR_LAT;
    end else if (fclk_rise) begin
      case (br_q)
        BR_LAT: begin
          if (lat_q == 3'h0) begin
            word_ld = 1'b1;
            left_d  = burst_words - 5'h01;
            br_d    = BR_DATA;
          end else begin
            lat_d = lat_q - 3'h1;
          end
        end
        BR_DATA: begin
          if (left_q == 5'h00 && !bl_cont) begin
            br_d = BR_DONE;
          end else begin
            word_ld = 1'b1;
            left_d  = left_q - 5'h01;
          end
        end
        default: ;
      endcase
      if (word_ld && rstate_q == RS_ARRAY) begin
        cur_d = cur_q + 16'h0001;
      end
    end
  end
  // Clocked state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_q   <= 4'hF;
      dec_q    <= DEC_IDLE;
      rstate_q <= RS_ARRAY;
      rcr_q    <= RCR_RST;
      br_q     <= BR_IDLE;
      cur_q    <= '0;
      lat_q    <= 3'h0;
      left_q   <= 5'h00;
    end else begin
      prev_q   <= {ce_n, adv_n, we_n, fclk};
      dec_q    <= dec_d;
      rstate_q <= rstate_d;
      rcr_q    <= rcr_d;
      br_q     <= br_d;
      cur_q    <= cur_d;
      lat_q    <= lat_d;
      left_q   <= left_d;
    end
  end
  // Status errors: hardware set wins over any clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) err_q <= 2'h0;
    else if (err_set) err_q <= 2'h3;
    else if (err_clr_cmd) err_q <= 2'h0;
    else err_q <= err_q & ~sw_clr;
  end
  // Protection register program
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prog_cnt_q  <= 8'h00;
      prot_addr_q <= '0;
      prot_data_q <= '0;
    end else if (prot_start) begin
      prog_cnt_q  <= 8'(PROG_CYC);
      prot_addr_q <= addr;
      prot_data_q <= din;
    end else if (!prog_idle) begin
      prog_cnt_q  <= prog_cnt_q - 8'h01;
    end
  end
  // Initial access delay on a new page
  wire logic new_page = ~ce_n & ~adv_n &
    (addr[ADDR_W-1:2] != cur_q[ADDR_W-1:2]);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) acc_q <= 3'(ACCESS_CYC);
    else if (ce_fall || new_page) acc_q <= 3'(ACCESS_CYC);
    else if (acc_q != 3'h0) acc_q <= acc_q - 3'h1;
  end
  // Data pins and wait
  wire logic out_en   = ~ce_n & ~oe_n;
  wire logic sync_out = br_q == BR_DATA || br_q == BR_DONE;
  wire logic wait_act = ~rd_async & ~ce_n & (br_q == BR_LAT);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_o    <= '0;
      dq_oe_o <= 1'b0;
      wait_o  <= 1'b0;
    end else begin
      if ((rd_async && acc_q == 3'h0) || word_ld) dq_o <= sel_word;
      dq_oe_o <= out_en & (rd_async ? (acc_q == 3'h0) : sync_out);
      wait_o  <= wait_act ^ ~rcr_q[RCR_WPOL_BIT];
    end
  end
  // APB answer, one wait-free access cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o   <= 32'h0000_0000;
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      arr_addr_q <= '0;
    end else begin
      pready_o  <= apb_setup;
      pslverr_o <= apb_setup & ~mapped;
      if (apb_setup) prdata_o <= rd_mux;
      if (apb_wr && hit_aadr) arr_addr_q <= pwdata_i[ARR_AW-1:0];
      else if (apb_wr && hit_adat) arr_addr_q <= arr_addr_q + 6'h01;
    end
  end
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_SEQ_ERR: assert property (
    wr_evt && dec_q == DEC_SETUP && !lock_cmd && !cfg_load |=> err_q == 2'h3)
    else $error("sequence error not flagged");
  AST_LOCK: assert property (
    lock_cmd && code == CMD_LOCK |=> lock_q[$past(blk)][0])
    else $error("block not locked");
  AST_UNLOCK_DOWN: assert property (
    lock_cmd && code == CMD_UNLOCK && lock_cur[1]
      |=> lock_q[$past(blk)] == 2'h3)
    else $error("locked-down block changed");
  AST_LOCKDOWN: assert property (
    lock_cmd && code == CMD_LOCKDOWN |=> lock_q[$past(blk)] == 2'h3)
    else $error("block not locked down");
  AST_PROT: assert property (
    prot_start |=> !sr_word[7] [*8])
    else $error("program not busy");
  AST_CFG_LOAD: assert property (
    cfg_load |=> rcr_q == $past(addr) && rstate_q == RS_ARRAY)
    else $error("config word not loaded");
  AST_RESET_DEF: assert property (
    $past(rst_i) |-> rcr_q == RCR_RST && rstate_q == RS_ARRAY &&
      dec_q == DEC_IDLE)
    else $error("reset defaults wrong");
  AST_RSTATE_HOLD: assert property (
    !wr_evt |=> $stable(rstate_q))
    else $error("read state moved without command");
  AST_ASYNC_WAIT: assert property (
    rd_async |=> wait_o == ~$past(rcr_q[RCR_WPOL_BIT]))
    else $error("wait asserted in page mode");
  AST_PAGE_WORD: assert property (
    rd_async && acc_q == 3'h0 |=> dq_o == $past(sel_word))
    else $error("page word not driven");
  AST_NONARRAY_REPEAT: assert property (
    word_ld && rstate_q != RS_ARRAY |=> cur_q == $past(cur_q))
    else $error("non-array burst advanced");
  COV_LOCK: cover property (lock_cmd && code == CMD_LOCKDOWN);
  COV_CFG: cover property (cfg_load ##[1:200] word_ld);
  COV_ERR: cover property (err_set);
  COV_BURST_DONE: cover property (br_q == BR_DATA ##1 br_q == BR_DONE);
endmodule : fcfg_flash_ctrl

/* design/fcfg_in_sync.sv */
// Two-flop synchroniser for the flash bus pins
module fcfg_in_sync #(
  parameter int unsigned   W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Pins in, synchronised out
  input  wire logic [W-1:0]  in_i,
  output wire logic [W-1:0]  out_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= in_i;
      sync_q <= meta_q;
    end
  end

  assign out_o = sync_q;
endmodule : fcfg_in_sync

/* design/fcfg_mem_if.sv */
// Interface between the controller and the page memory
interface fcfg_mem_if;
  import fcfg_pkg::*;
  logic                  we;
  logic [ARR_AW-1:0]     waddr;
  logic [DATA_W-1:0]     wdata;
  logic [PAGE_AW-1:0]    raddr;
  logic [4*DATA_W-1:0]   rpage;
  modport ctl (output we, output waddr, output wdata, output raddr,
               input rpage);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rpage);
endinterface : fcfg_mem_if

/* design/fcfg_page_mem.sv */
// Array storage read out one four-word page at a time
module fcfg_page_mem
  import fcfg_pkg::*;
(
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  // Controller side
  fcfg_mem_if.mem    bus
);
  logic [DATA_W-1:0] word_q [2**ARR_AW];

  always_ff @(posedge clk_i) begin
    if (bus.we) begin
      word_q[bus.waddr] <= bus.wdata;
    end
  end

  // Whole page sensed in one cycle
  for (genvar w = 0; w < 4; w++) begin : g_word
    logic [DATA_W-1:0] q;
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        q <= '0;
      end else begin
        q <= word_q[{bus.raddr, 2'(w)}];
      end
    end
    assign bus.rpage[w*DATA_W +: DATA_W] = q;
  end
endmodule : fcfg_page_mem

/* design/fcfg_pkg.sv */
// Constants and types for the flash command decoder and read path
package fcfg_pkg;

  // APB register byte offsets
  localparam logic [7:0]  OFF_STATUS   = 8'h00;
  localparam logic [7:0]  OFF_RDCFG    = 8'h04;
  localparam logic [7:0]  OFF_RDSTATE  = 8'h08;
  localparam logic [7:0]  OFF_LOCKS    = 8'h0C;
  localparam logic [7:0]  OFF_ARR_ADDR = 8'h10;
  localparam logic [7:0]  OFF_ARR_DATA = 8'h14;
  localparam logic [7:0]  OFF_PROT     = 8'h18;

  // Command codes on the flash bus
  localparam logic [7:0]  CMD_SETUP_SHARED = 8'h60;
  localparam logic [7:0]  CMD_LOCK         = 8'h01;
  localparam logic [7:0]  CMD_UNLOCK       = 8'hD0;
  localparam logic [7:0]  CMD_LOCKDOWN     = 8'h2F;
  localparam logic [7:0]  CMD_PROT_SETUP   = 8'hC0;
  localparam logic [7:0]  CMD_LOAD_CFG     = 8'h03;
  localparam logic [7:0]  CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0]  CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0]  CMD_READ_IDENT   = 8'h90;
  localparam logic [7:0]  CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0]  CMD_READ_QUERY   = 8'h98;

  // Read configuration word fields and reset value
  localparam int          RCR_MODE_BIT  = 15;
  localparam int          RCR_LC_HI     = 13;
  localparam int          RCR_LC_LO     = 11;
  localparam int          RCR_WPOL_BIT  = 10;
  localparam int          RCR_BL_HI     = 2;
  localparam int          RCR_BL_LO     = 0;
  localparam logic [15:0] RCR_RST       = 16'hBFC7;
  localparam logic [2:0]  BL_4          = 3'h1;
  localparam logic [2:0]  BL_8          = 3'h2;
  localparam logic [2:0]  BL_16         = 3'h3;

  // Geometry
  localparam int          ADDR_W   = 16;
  localparam int          DATA_W   = 16;
  localparam int          BLK_LO   = 12;
  localparam int          BLK_W    = 4;
  localparam int          NUM_BLK  = 16;
  localparam int          ARR_AW   = 6;
  localparam int          PAGE_AW  = 4;

  // Non-array read words; identifier and query values are arbitrary
  localparam logic [7:0]  ID_OFF_CFG = 8'h05;
  localparam logic [15:0] ID_WORD    = 16'h0001;
  localparam logic [15:0] QUERY_WORD = 16'h0002;
  localparam logic [1:0]  LOCK_RST   = 2'h1;

  // Timing at 200 MHz
  localparam int          CLK_NS     = 5;
  localparam int          ACCESS_NS  = 20;
  localparam int          ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PROG_NS    = 1000;
  localparam int          PROG_CYC   = PROG_NS / CLK_NS;

  // Pin synchroniser vector: ce, adv, we, oe, fclk, addr, dq
  localparam int           SYNC_W   = 37;
  localparam logic [36:0]  SYNC_RST = 37'h1F_0000_0000;

  typedef enum logic [1:0] {RS_ARRAY, RS_IDENT, RS_STATUS, RS_QUERY}
    fcfg_rstate_e;
  typedef enum logic [1:0] {DEC_IDLE, DEC_SETUP, DEC_PROT} fcfg_dec_e;
  typedef enum logic [1:0] {BR_IDLE, BR_LAT, BR_DATA, BR_DONE} fcfg_burst_e;

endpackage : fcfg_pkg

/* verif/fcfg_host_model.sv */
// Host memory controller model driving the flash bus pins
module fcfg_host_model
  import fcfg_pkg::*;
(
  // Clock
  input  wire logic               clk_i,
  // Pins toward the device
  output logic                    chip_sel_n_o,
  output logic                    address_valid_n_o,
  output logic                    write_en_n_o,
  output logic                    output_en_n_o,
  output logic                    flash_clk_o,
  output logic [ADDR_W-1:0]       flash_addr_o,
  output logic [DATA_W-1:0]       dq_o,
  // Pins from the device
  input  wire logic [DATA_W-1:0]  dq_i,
  input  wire logic               dq_oe_i,
  input  wire logic               wait_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    chip_sel_n_o      = 1'b1;
    address_valid_n_o = 1'b0;
    write_en_n_o      = 1'b1;
    output_en_n_o     = 1'b1;
    flash_clk_o       = 1'b1;
    flash_addr_o      = 16'h0000;
    dq_o              = 16'h0000;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold

  // Write cycle, data inverted once released
  task automatic cmd(input logic [15:0] d, input logic [15:0] a);
    chip_sel_n_o  <= 1'b0;
    output_en_n_o <= 1'b1;
    flash_addr_o  <= a;
    dq_o          <= d;
    hold(1);
    write_en_n_o <= 1'b0;
    hold(4);
    write_en_n_o <= 1'b1;
    hold(4);
    chip_sel_n_o <= 1'b1;
    dq_o         <= ~d;
    hold(4);
  endtask : cmd

  task automatic aread(input logic [15:0] a, output logic [15:0] d,
                       output logic oe, output logic wt);
    chip_sel_n_o  <= 1'b0;
    output_en_n_o <= 1'b0;
    flash_addr_o  <= a;
    hold(10);
    d  = dq_i;
    oe = dq_oe_i;
    wt = wait_i;
  endtask : aread

  task automatic bstart(input logic [15:0] a);
    chip_sel_n_o  <= 1'b0;
    output_en_n_o <= 1'b0;
    flash_addr_o  <= a;
    hold(4);
    address_valid_n_o <= 1'b1;
    hold(4);
  endtask : bstart

  task automatic rise(output logic [15:0] d, output logic oe);
    flash_clk_o <= 1'b0;
    hold(4);
    flash_clk_o <= 1'b1;
    hold(6);
    d  = dq_i;
    oe = dq_oe_i;
  endtask : rise

  // Deselect, address no longer held
  task automatic idle();
    chip_sel_n_o      <= 1'b1;
    output_en_n_o     <= 1'b1;
    address_valid_n_o <= 1'b0;
    flash_addr_o      <= ~flash_addr_o;
    hold(4);
  endtask : idle
endmodule : fcfg_host_model

/* verif/tb_top.sv */
// Self-checking bench for the flash command decoder and read path
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fcfg_pkg::*;
  logic        clk_i, rst_i, psel_i, penable_i, pwrite_i;
  logic        pready_o, pslverr_o, err, oe, wt;
  logic        ce_n, adv_n, we_n, oe_n, fclk, dq_oe, wait_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [15:0] fa, dqw, dqr, w;
  logic [7:0]  rcmd [4] = '{CMD_READ_IDENT, CMD_READ_STATUS,
                            CMD_READ_QUERY, CMD_READ_ARRAY};
  int          n_fail = 0;
  int          samples_checked = 0;

  fcfg_flash_ctrl u_fcfg_flash_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .chip_sel_n_i(ce_n), .address_valid_n_i(adv_n), .write_en_n_i(we_n),
    .output_en_n_i(oe_n), .flash_clk_i(fclk), .flash_addr_i(fa),
    .dq_i(dqw), .dq_o(dqr), .dq_oe_o(dq_oe), .wait_o(wait_o));

  fcfg_host_model u_fcfg_host_model (
    .clk_i(clk_i), .chip_sel_n_o(ce_n), .address_valid_n_o(adv_n),
    .write_en_n_o(we_n), .output_en_n_o(oe_n), .flash_clk_o(fclk),
    .flash_addr_o(fa), .dq_o(dqw), .dq_i(dqr), .dq_oe_i(dq_oe),
    .wait_i(wait_o));

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k = 0;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t no ready from slave", $time);
      conclude();
    end else begin
      rd        = prdata_o;
      err       = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdc

  task automatic two(input logic [7:0] c, input logic [15:0] a);
    u_fcfg_host_model.cmd({8'h00, CMD_SETUP_SHARED}, a);
    u_fcfg_host_model.cmd({8'h00, c}, a);
  endtask : two

  // Step s of zero repeats the word
  task automatic burst(input logic [15:0] a, input logic [15:0] b,
                       input logic [15:0] s);
    u_fcfg_host_model.bstart(a);
    for (int i = 0; i < 6; i++) begin
      u_fcfg_host_model.rise(w, oe);
      if (i < 2) chk({31'h0, oe}, 32'h0000_0000);
      else chk({15'h0, oe, w}, {15'h0, 1'b1, 16'(b + s * (i - 2))});
    end
    u_fcfg_host_model.idle();
  endtask : burst

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    rst_i     = 1'b1;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    paddr_i   = 8'h00;
    pwdata_i  = 32'h0000_0000;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(OFF_RDCFG, {16'h0000, RCR_RST});
    rdc(OFF_RDSTATE, 32'h0000_0000);
    rdc(OFF_LOCKS, 32'h5555_5555);
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    u_fcfg_host_model.cmd({8'h00, CMD_SETUP_SHARED}, 16'h3000);
    rdc(OFF_RDSTATE, 32'h0000_0004);
    u_fcfg_host_model.cmd({8'h00, CMD_UNLOCK}, 16'h3000);
    rdc(OFF_LOCKS, 32'h5555_5515);
    two(CMD_LOCKDOWN, 16'h3000);
    rdc(OFF_LOCKS, 32'h5555_55D5);
    two(CMD_UNLOCK, 16'h3000);
    two(CMD_UNLOCK, 16'h5000);
    rdc(OFF_LOCKS, 32'h5555_51D5);
    two(CMD_LOCK, 16'h5000);
    rdc(OFF_LOCKS, 32'h5555_55D5);
    two(CMD_READ_ARRAY, 16'h0000);
    rdc(OFF_STATUS, 32'h0000_00B0);
    apb(1'b1, OFF_STATUS, 32'h0000_0030);
    rdc(OFF_STATUS, 32'h0000_0080);
    two(CMD_PROT_SETUP, 16'h0000);
    rdc(OFF_STATUS, 32'h0000_00B0);
    u_fcfg_host_model.cmd({8'h00, CMD_CLEAR_STATUS}, 16'h0000);
    rdc(OFF_STATUS, 32'h0000_0080);
    u_fcfg_host_model.cmd({8'h00, CMD_PROT_SETUP}, 16'h0000);
    u_fcfg_host_model.cmd(16'hABCD, 16'h0012);
    rdc(OFF_STATUS, 32'h0000_0000);
    rdc(OFF_PROT, 32'hABCD_0012);
    repeat (200) @(posedge clk_i);
    rdc(OFF_STATUS, 32'h0000_0080);
    for (int i = 0; i < 4; i++) begin
      u_fcfg_host_model.cmd({8'h00, rcmd[i]}, 16'h0000);
      rdc(OFF_RDSTATE, 32'((i + 1) % 4));
    end
    apb(1'b1, OFF_ARR_ADDR, 32'h0000_0004);
    for (int i = 0; i < 4; i++) apb(1'b1, OFF_ARR_DATA, 32'h1110 + i);
    for (int i = 3; i >= 0; i--) begin
      u_fcfg_host_model.aread(16'(4 + i), w, oe, wt);
      chk({14'h0, wt, oe, w}, 32'h0001_1110 + i);
    end
    u_fcfg_host_model.idle();
    u_fcfg_host_model.cmd({8'h00, CMD_READ_IDENT}, 16'h0000);
    two(CMD_LOAD_CFG, 16'h1481);
    rdc(OFF_RDCFG, 32'h0000_1481);
    rdc(OFF_RDSTATE, 32'h0000_0000);
    burst(16'h0004, 16'h1110, 16'h0001);
    u_fcfg_host_model.cmd({8'h00, CMD_READ_QUERY}, 16'h0000);
    burst(16'h0000, QUERY_WORD, 16'h0000);
    u_fcfg_host_model.cmd({8'h00, CMD_READ_IDENT}, 16'h0000);
    burst(16'(ID_OFF_CFG), 16'h1481, 16'h0000);
    conclude();
  end
endmodule : tb_top
